/* File: src/eeprom_two_wire_slave_frontend.v */
`timescale 1ns/1ns
`include "eeprom_map.vh"
// How it works
// - Receiver acknowledges each byte by pulling data low.
// - Transmitter releases; ack driven during ninth clock.
// - Byte after slave address is array address.
// - Pages are sixteen bytes on sixteen-byte boundaries.
// - One page block: sixteen pages of sixteen bytes.
// - All bits timed by external serial clock.
// - Data line is open drain: low or released.
// - Protect high blocks upper-half programming, reads allowed.
// - Protect low allows full reads and writes.
// - Protected write: ack addresses, withhold data ack.
// - Unconnected protect input counts as low.
// - Select field matched to high, mid, low pins.
// - Full-size part: no select bits pick page blocks.
// - Master clocks everything; device never drives clock.
// - Data changes only while clock is low.
// - Start: data falls while clock high.
// - Ignore everything until a start is seen.
// - Stop: data rises while clock high; standby.
// - After write, standby needs second stop after cycle.
// - Device-type code must match upper four bits.
// - Last address bit: one reads, zero writes.
// - During write cycle: interface off, no ack.
module eeprom_two_wire_slave_frontend #(
   parameter WR_CYCLES = `WRITE_CYCLE_CYCLES, // Internal write-cycle length in reference clocks.
   parameter TMR_W     = 20                   // Width of the write-cycle timer.
) (
   input  wire       ref_clk,             // 50 MHz reference clock.
   input  wire       reset_n,             // Asynchronous reset, active low.
   input  wire       scl_in,              // Serial clock pin level.
   input  wire       sda_in,              // Serial data pin level.
   output wire       sda_out,             // Serial data drive value, always low.
   output wire       sda_oe,              // High while the device pulls data low.
   input  wire       select_pin_high,     // Select strap, high bit.
   input  wire       select_pin_mid,      // Select strap, middle bit.
   input  wire       select_pin_low,      // Select strap, low bit.
   input  wire       write_protect_input, // Upper-half write protect.
   output reg  [7:0] array_addr,          // Current array address.
   input  wire [7:0] rd_data,             // Array byte at array_addr.
   output reg        byte_wr,             // One-cycle pulse: byte accepted for programming.
   output reg  [7:0] byte_wr_addr,        // Address of the accepted byte.
   output reg  [7:0] byte_wr_data,        // Value of the accepted byte.
   output reg        prog_start,          // One-cycle pulse: program cycle begins.
   output wire       busy,                // High during the internal write cycle.
   input  wire [1:0] reg_addr,            // Register port address.
   input  wire [7:0] reg_wdata,           // Register port write data.
   input  wire       reg_wr,              // Register write strobe.
   input  wire       reg_rd,              // Register read strobe.
   output reg  [7:0] reg_rdata            // Register read data, one cycle after the strobe.
);

   // One-hot states of the bus front end.
   localparam [5:0] S_IDLE  = 6'h01;    // Standby: waits for a start; a stop clears the owed second stop or starts a pending write.
   localparam [5:0] S_DEV   = 6'h02;    // Receiving the slave address.
   localparam [5:0] S_WORD  = 6'h04;    // Receiving the array address.
   localparam [5:0] S_WDATA = 6'h08;    // Receiving data bytes.
   localparam [5:0] S_RDATA = 6'h10;    // Sending data bytes.
   localparam [5:0] S_BUSY  = 6'h20;    // Internal write cycle, deaf to the bus.
   localparam [31:0] WR_LAST = WR_CYCLES - 1; // Last timer value of the write cycle.

   wire [5:0]       pins_s;             // Synchronised pin levels.
   wire             scl_s;              // Synchronised serial clock.
   wire             sda_s;              // Synchronised serial data.
   wire             wp_s;               // Synchronised write protect.
   wire [2:0]       sel_s;              // Synchronised straps, high to low.
   reg              scl_d_r;            // Serial clock one cycle back.
   reg              sda_d_r;            // Serial data one cycle back.
   wire             scl_rise;           // Serial clock rising edge.
   wire             scl_fall;           // Serial clock falling edge.
   wire             start_cond;         // Start seen on the bus.
   wire             stop_cond;          // Stop seen on the bus.
   reg  [5:0]       state_r;            // Front-end state.
   reg  [3:0]       bit_cnt_r;          // Serial clocks seen in this byte, 0 to 9.
   reg  [7:0]       rx_sh_r;            // Incoming shift register.
   reg  [7:0]       tx_sh_r;            // Outgoing byte.
   reg              drive_low_r;        // Pull the data line low.
   reg              acking_r;           // Device acknowledged the current byte.
   reg              read_dir_r;         // Direction latched from the slave address.
   reg              master_ack_r;       // Master acknowledged the byte just sent.
   reg              wr_pending_r;       // A byte awaits programming at the next stop.
   reg              await_stop_r;       // Write cycle over, second stop still owed.
   reg  [TMR_W-1:0] wr_tmr_r;           // Write-cycle timer.
   reg  [7:0]       ctrl_r;             // Control register.
   reg  [7:0]       last_data_r;        // Last data byte received on the bus.
   wire             bus_en;             // Software lets the front end answer the bus.
   wire             dev_match;          // Slave address selects this device.
   wire             protected_wr;       // Current data byte falls in a guarded location.

   // Next array address: page mode wraps inside sixteen bytes, read mode runs over the block.
   function [7:0] next_addr;
      input [7:0] addr;
      input       page_mode;
      begin
         if (page_mode) begin
            next_addr = {addr[7:`PAGE_OFFSET_MSB+1], addr[`PAGE_OFFSET_MSB:0] + 4'h1};
         end else begin
            next_addr = addr + 8'h01;
         end
      end
   endfunction

   // Every pin crosses into the reference domain through two flops before use.
   // Clock and data reset to their idle high level, so no false edge follows reset.
   pin_sync #(
      .WIDTH    (6),
      .INIT     (6'h30)
   ) u_pin_sync (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .async_in ({scl_in, sda_in, write_protect_input, select_pin_high, select_pin_mid, select_pin_low}),
      .sync_out (pins_s)
   );

   assign scl_s = pins_s[5];
   assign sda_s = pins_s[4];
   // An open pin reads low thanks to the board-level pull-down, so no override is needed here.
   assign wp_s  = pins_s[3];
   assign sel_s = pins_s[2:0];

   // Edges are found from the synchronised levels only; the serial clock paces every bit.
   assign scl_rise   = scl_s & ~scl_d_r;
   assign scl_fall   = ~scl_s & scl_d_r;
   // Data moving while the clock is high is a start or stop, never a data bit.
   assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_cond  = scl_s & scl_d_r & ~sda_d_r & sda_s;

   // All three straps are present, so the whole select field picks the device, none the block.
   assign dev_match    = (rx_sh_r[7:4] == `DEVICE_TYPE_CODE) && (rx_sh_r[3:1] == sel_s);
   assign protected_wr = wp_s & array_addr[`ADDR_UPPER_BIT];

   assign bus_en  = ctrl_r[`CTRL_BUS_EN_BIT];
   assign busy    = (state_r == S_BUSY);
   // The pin is only ever pulled low or let go; the clock pin is never driven at all.
   assign sda_out = 1'b0;
   assign sda_oe  = drive_low_r;

   // Delayed copies of the synchronised lines for edge and condition detection.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // Bus protocol engine: conditions first, then clock edges within a byte.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r      <= S_IDLE;
         bit_cnt_r    <= 4'h0;
         rx_sh_r      <= 8'h00;
         tx_sh_r      <= 8'h00;
         drive_low_r  <= 1'b0;
         acking_r     <= 1'b0;
         read_dir_r   <= 1'b0;
         master_ack_r <= 1'b0;
         wr_pending_r <= 1'b0;
         await_stop_r <= 1'b0;
         wr_tmr_r     <= {TMR_W{1'b0}};
         array_addr   <= 8'h00;
         byte_wr      <= 1'b0;
         byte_wr_addr <= 8'h00;
         byte_wr_data <= 8'h00;
         prog_start   <= 1'b0;
         last_data_r  <= 8'h00;
      end else begin
         byte_wr    <= 1'b0;
         prog_start <= 1'b0;
         case (state_r)
            S_BUSY: begin
               // Deaf to the bus, line released, slave address not acknowledged.
               drive_low_r <= 1'b0;
               if (wr_tmr_r == WR_LAST[TMR_W-1:0]) begin
                  wr_tmr_r     <= {TMR_W{1'b0}};
                  await_stop_r <= 1'b1;
                  state_r      <= S_IDLE;
               end else begin
                  wr_tmr_r <= wr_tmr_r + {{(TMR_W-1){1'b0}}, 1'b1};
               end
            end
            default: begin
               if (stop_cond) begin
                  // A stop after accepted data starts the program cycle instead of standby.
                  drive_low_r <= 1'b0;
                  bit_cnt_r   <= 4'h0;
                  if (wr_pending_r) begin
                     wr_pending_r <= 1'b0;
                     prog_start   <= 1'b1;
                     state_r      <= S_BUSY;
                  end else begin
                     await_stop_r <= 1'b0;
                     state_r      <= S_IDLE;
                  end
               end else if (start_cond && bus_en) begin
                  // A start anywhere drops the partial byte and matches afresh.
                  drive_low_r <= 1'b0;
                  bit_cnt_r   <= 4'h0;
                  acking_r    <= 1'b0;
                  state_r     <= S_DEV;
               end else if (state_r == S_IDLE) begin
                  drive_low_r <= 1'b0;
               end else if (scl_rise) begin
                  if (bit_cnt_r < `BITS_PER_BYTE) begin
                     rx_sh_r <= {rx_sh_r[6:0], sda_s};
                  end else begin
                     master_ack_r <= ~sda_s;
                  end
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_r == `BITS_PER_BYTE) begin
                     // Byte complete: decide the acknowledge for the ninth clock.
                     acking_r    <= 1'b0;
                     drive_low_r <= 1'b0;
                     case (state_r)
                        S_DEV: begin
                           if (dev_match) begin
                              read_dir_r  <= rx_sh_r[0];
                              acking_r    <= 1'b1;
                              drive_low_r <= 1'b1;
                           end else begin
                              state_r <= S_IDLE;
                           end
                        end
                        S_WORD: begin
                           array_addr  <= rx_sh_r;
                           acking_r    <= 1'b1;
                           drive_low_r <= 1'b1;
                        end
                        S_WDATA: begin
                           last_data_r <= rx_sh_r;
                           if (!protected_wr) begin
                              byte_wr      <= 1'b1;
                              byte_wr_addr <= array_addr;
                              byte_wr_data <= rx_sh_r;
                              array_addr   <= next_addr(array_addr, 1'b1);
                              wr_pending_r <= 1'b1;
                              acking_r     <= 1'b1;
                              drive_low_r  <= 1'b1;
                           end else begin
                              state_r <= S_IDLE;
                           end
                        end
                        default: begin
                           // Sending: the device lets go so the master can answer.
                           acking_r <= 1'b0;
                        end
                     endcase
                  end else if (bit_cnt_r == `ACK_CLOCK) begin
                     // End of the ninth clock: release and move to the next byte.
                     bit_cnt_r   <= 4'h0;
                     drive_low_r <= 1'b0;
                     case (state_r)
                        S_DEV: begin
                           if (read_dir_r) begin
                              tx_sh_r     <= rd_data;
                              drive_low_r <= ~rd_data[7];
                              array_addr  <= next_addr(array_addr, 1'b0);
                              state_r     <= S_RDATA;
                           end else begin
                              state_r <= S_WORD;
                           end
                        end
                        S_WORD: begin
                           state_r <= S_WDATA;
                        end
                        S_RDATA: begin
                           if (master_ack_r) begin
                              tx_sh_r     <= rd_data;
                              drive_low_r <= ~rd_data[7];
                              array_addr  <= next_addr(array_addr, 1'b0);
                           end else begin
                              state_r <= S_IDLE;
                           end
                        end
                        default: begin
                           state_r <= state_r;
                        end
                     endcase
                  end else if (state_r == S_RDATA) begin
                     // Next data bit changes only after the clock has fallen.
                     drive_low_r <= ~tx_sh_r[3'h7 - bit_cnt_r[2:0]];
                  end
               end
            end
         endcase
      end
   end

   // Control register: software may take the front end off the bus.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= `CTRL_RESET;
      end else if (reg_wr && (reg_addr == `REG_CONTROL)) begin
         ctrl_r <= reg_wdata;
      end
   end

   // Register read data stand in the cycle after the read strobe only.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `REG_STATUS: begin
               reg_rdata <= {3'h0, read_dir_r, wp_s, wr_pending_r, busy | await_stop_r, state_r == S_IDLE};
            end
            `REG_ARRAY_ADDR: begin
               reg_rdata <= array_addr;
            end
            `REG_LAST_DATA: begin
               reg_rdata <= last_data_r;
            end
            default: begin
               reg_rdata <= ctrl_r;
            end
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule // eeprom_two_wire_slave_frontend

/* File: src/eeprom_map.vh */
`ifndef EEPROM_MAP_VH
`define EEPROM_MAP_VH

// Fixed device-type code that the upper four slave-address bits must match.
`define DEVICE_TYPE_CODE     4'ha
// Reference clock rate in kHz.
`define REF_CLK_KHZ          50000
// Longest internal write-cycle time, in milliseconds.
`define WRITE_CYCLE_TIME_MS  10
// Write-cycle count in reference-clock cycles (the longest time, an exact product).
`define WRITE_CYCLE_CYCLES   (`WRITE_CYCLE_TIME_MS * `REF_CLK_KHZ)

// Register offsets on the plain register port.
`define REG_STATUS           2'h0
`define REG_ARRAY_ADDR       2'h1
`define REG_LAST_DATA        2'h2
`define REG_CONTROL          2'h3

// Status register field positions.
`define STAT_STANDBY_BIT     0
`define STAT_BUSY_BIT        1
`define STAT_PENDING_BIT     2
`define STAT_PROTECT_BIT     3
`define STAT_READ_BIT        4

// Control register field position and reset value.
`define CTRL_BUS_EN_BIT      0
`define CTRL_RESET           8'h01

// Array address layout: the top bit marks the protectable upper half.
`define ADDR_UPPER_BIT       7
`define PAGE_OFFSET_MSB      3

// Bit counter values: eight data bits, then the acknowledge clock.
`define BITS_PER_BYTE        4'h8
`define ACK_CLOCK            4'h9

`endif

/* File: src/pin_sync.v */
`timescale 1ns/1ns
// Two-stage synchroniser for pins that arrive from outside the reference clock's domain.
module pin_sync #(
   parameter             WIDTH = 1,            // Number of independent level signals.
   parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}} // Reset levels, each the idle level of its pin.
) (
   input  wire             ref_clk,  // Reference clock.
   input  wire             reset_n,  // Asynchronous reset, active low.
   input  wire [WIDTH-1:0] async_in, // Raw pin levels.
   output reg  [WIDTH-1:0] sync_out  // Levels safe for the clock domain.
);

   reg [WIDTH-1:0] meta_r;           // First stage, read only by the second stage.

   // Both stages reset to the idle levels; the first stage feeds nothing but the second.
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r   <= INIT;
         sync_out <= INIT;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule // pin_sync

/* File: verif/eeprom_frontend_monitor.sv */
`timescale 1ns/1ns
// Watches the pins, write handshake and register read path.
module eeprom_frontend_monitor #(
   parameter WR_CYCLES = 500000          // Write-cycle length in clocks.
) (
   input wire       ref_clk,             // Clock.
   input wire       reset_n,             // Reset, active low.
   input wire       scl_in,              // Serial clock level.
   input wire       sda_out,             // Data drive value.
   input wire       sda_oe,              // Device pulls data low.
   input wire       write_protect_input, // Upper-half protect.
   input wire [7:0] array_addr,          // Address counter.
   input wire       byte_wr,             // Byte accepted.
   input wire [7:0] byte_wr_addr,        // Address of that byte.
   input wire       prog_start,          // Program cycle begins.
   input wire       busy,                // Write cycle running.
   input wire [1:0] reg_addr,            // Register address.
   input wire       reg_rd,              // Register read strobe.
   input wire [7:0] reg_rdata            // Register read data.
);
   logic [31:0] busy_cnt_r;              // Length of the running write cycle.

   // Cleared while idle: each write cycle is timed alone.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_cnt_r <= 32'h0;
      end else begin
         busy_cnt_r <= busy ? busy_cnt_r + 32'h1 : 32'h0;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // An acknowledge or low bit holds most of a link clock.
   sequence s_ack_hold; sda_oe [*6]; endsequence
   // The write cycle runs on after its start.
   sequence s_busy_run; busy [*8]; endsequence

   property p_open_drain; sda_out == 1'b0; endproperty
   property p_quiet_busy; busy |-> !sda_oe; endproperty
   property p_prog_busy; prog_start |=> s_busy_run; endproperty
   property p_busy_len; $fell(busy) |-> busy_cnt_r inside {[WR_CYCLES-1:WR_CYCLES+1]}; endproperty
   property p_wp_upper;
      byte_wr && write_protect_input && $past(write_protect_input, 4) |-> !byte_wr_addr[7];
   endproperty
   property p_change_low; $changed(sda_oe) |-> !$past(scl_in); endproperty
   property p_ack_hold; $rose(sda_oe) |-> s_ack_hold; endproperty
   property p_reset_quiet; $rose(reset_n) |-> !sda_oe [*3]; endproperty
   property p_addr_reg; reg_rd && reg_addr == 2'h1 |=> reg_rdata == $past(array_addr); endproperty

   a_open_drain: assert property (p_open_drain) else $error("data line driven high");
   a_quiet_busy: assert property (p_quiet_busy) else $error("data pulled in write cycle");
   a_prog_busy: assert property (p_prog_busy) else $error("write cycle not started");
   a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
   a_wp_upper: assert property (p_wp_upper) else $error("protected byte accepted");
   a_change_low: assert property (p_change_low) else $error("data moved with clock high");
   a_ack_hold: assert property (p_ack_hold) else $error("acknowledge too short");
   a_reset_quiet: assert property (p_reset_quiet) else $error("data pulled after reset");
   a_addr_reg: assert property (p_addr_reg) else $error("address readback wrong");
endmodule // eeprom_frontend_monitor

bind eeprom_two_wire_slave_frontend eeprom_frontend_monitor #(.WR_CYCLES(WR_CYCLES)) i_eeprom_frontend_monitor (
   .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .write_protect_input(write_protect_input), .array_addr(array_addr), .byte_wr(byte_wr),
   .byte_wr_addr(byte_wr_addr), .prog_start(prog_start), .busy(busy), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata));

/* File: verif/two_wire_master.sv */
`timescale 1ns/1ns
// Bus master model: owns the clock and pulls data low, timed on ref_clk.
module two_wire_master (
   input  wire  ref_clk, // Bench clock.
   input  wire  sda_oe,  // Device pull on data.
   output logic scl,     // Serial clock, 8 bench clocks a period.
   output wire  sda      // Resolved data wire.
);
   logic pull_r = 1'b0;  // Master pull on data.

   initial scl = 1'b1;
   // Pulled-up wire: low while anyone pulls.
   assign sda = ~(pull_r | sda_oe);

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // One link clock: data moves mid low phase, sampled mid high phase.
   task automatic clk_bit(input logic b, output logic r);
      pull_r <= ~b;
      tick(2);
      scl <= 1'b1;
      tick(2);
      r = sda;
      tick(2);
      scl <= 1'b0;
      tick(2);
   endtask

   // Start or repeated start; the first wait lets a late acknowledge end.
   task automatic start();
      pull_r <= 1'b0;
      tick(3);
      scl <= 1'b1;
      tick(4);
      pull_r <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask

   // Stop; clock falls first so a stop from idle is no start.
   task automatic stop();
      scl <= 1'b0;
      tick(2);
      pull_r <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      pull_r <= 1'b0;
      tick(8);
   endtask

   // Eight bits msb first, then the ninth clock at ack_lvl.
   task automatic xfer(input logic [7:0] tx, input logic ack_lvl, output logic [7:0] rx, output logic acked);
      logic a;
      for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
      clk_bit(ack_lvl, a);
      acked = ~a;
   endtask
endmodule // two_wire_master

/* File: verif/eeprom_two_wire_slave_frontend_tb_top.sv */
`timescale 1ns/1ns
`define CHECK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("unexpected %s expected %h seen %h", nm, exp, got); end end
// Bench: master model on the link, register port driven by tasks.
module eeprom_two_wire_slave_frontend_tb_top;
   localparam int WR_CYC = 200;  // Short write cycle keeps the run brief.
   logic       ref_clk = 1'b0;   // Clock.
   logic       reset_n = 1'b0;   // Reset.
   logic       wp = 1'b0;        // Write protect.
   logic [2:0] sel = 3'b101;     // Straps high, mid, low.
   logic [7:0] rd_data = 8'h00;  // Array stand-in output.
   logic [1:0] reg_addr = 2'h0;  // Register address.
   logic [7:0] reg_wdata = 8'h00; // Register write data.
   logic       reg_wr = 1'b0;    // Write strobe.
   logic       reg_rd = 1'b0;    // Read strobe.
   wire        scl, sda, sda_oe, busy, byte_wr, prog_start;
   wire  [7:0] array_addr, byte_wr_addr, byte_wr_data, reg_rdata;
   int         n_mismatch = 0;   // Mismatches.
   int         tests_run = 0;    // Comparisons.
   int         n_prog = 0;       // Program starts seen.
   logic [15:0] wq[$];           // Accepted address and data.
   logic [7:0] rx;               // Last byte read.
   logic       ack;              // Last acknowledge.

   always #10 ref_clk = ~ref_clk;
   // Array stand-in: data are a fixed pattern of the address.
   always @(posedge ref_clk) rd_data <= array_addr ^ 8'h5a;
   // Log accepted bytes and program starts.
   always @(posedge ref_clk) begin
      if (byte_wr === 1'b1) wq.push_back({byte_wr_addr, byte_wr_data});
      if (prog_start === 1'b1) n_prog++;
   end

   eeprom_two_wire_slave_frontend #(.WR_CYCLES(WR_CYC), .TMR_W(20)) i_eeprom_two_wire_slave_frontend (
      .ref_clk(ref_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .select_pin_high(sel[2]), .select_pin_mid(sel[1]), .select_pin_low(sel[0]),
      .write_protect_input(wp), .array_addr(array_addr), .rd_data(rd_data), .byte_wr(byte_wr),
      .byte_wr_addr(byte_wr_addr), .byte_wr_data(byte_wr_data), .prog_start(prog_start), .busy(busy),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   two_wire_master mst (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

   task automatic print_verdict();
      if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand one cycle after the strobe.
   task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      d = reg_rdata;
   endtask

   // Bounded wait for the write cycle.
   task automatic wait_idle();
      int i;
      for (i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge ref_clk);
      if (i == 2000) begin
         n_mismatch++;
         print_verdict();
      end
   endtask

   // Write: slave address, array address, n data bytes, stop.
   task automatic wr(input logic [7:0] sa, aa, d0, input int n, input logic exp_sa, exp_d);
      mst.start();
      mst.xfer(sa, 1'b1, rx, ack);
      `CHECK("slave ack", exp_sa, ack)
      if (exp_sa) begin
         mst.xfer(aa, 1'b1, rx, ack);
         `CHECK("address ack", 1'b1, ack)
         for (int k = 0; k < n; k++) begin
            mst.xfer(d0 + 8'(k * 17), 1'b1, rx, ack);
            `CHECK("data ack", exp_d, ack)
         end
      end
      mst.stop();
   endtask

   initial begin
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      reg_read(2'h3, rx);
      `CHECK("control", 8'h01, rx)
      repeat (4) @(posedge ref_clk);
      wr(8'haa, 8'h0e, 8'h11, 3, 1'b1, 1'b1);
      `CHECK("wrap", 48'h0e11_0f22_0033, {wq[0], wq[1], wq[2]})
      `CHECK("prog", 1, n_prog)
      `CHECK("busy", 1'b1, busy)
      wr(8'haa, 8'h00, 8'h00, 0, 1'b0, 1'b0);
      wait_idle();
      wr(8'haa, 8'h00, 8'h00, 0, 1'b1, 1'b0);
      reg_read(2'h0, rx);
      `CHECK("standby", 2'b01, rx[1:0])
      wp <= 1'b1;
      wr(8'haa, 8'h80, 8'h55, 1, 1'b1, 1'b0);
      `CHECK("protected prog", 1, n_prog)
      reg_read(2'h2, rx);
      `CHECK("last data", 8'h55, rx)
      wr(8'haa, 8'h7f, 8'h66, 1, 1'b1, 1'b1);
      wait_idle();
      mst.stop();
      wp <= 1'b0;
      wr(8'haa, 8'h80, 8'h77, 1, 1'b1, 1'b1);
      `CHECK("accepted", {16'h7f66, 16'h8077, 32'd5}, {wq[3], wq[4], wq.size()})
      wait_idle();
      mst.stop();
      // Random read: set the address, repeated start, two bytes.
      mst.start();
      mst.xfer(8'haa, 1'b1, rx, ack);
      mst.xfer(8'h40, 1'b1, rx, ack);
      mst.start();
      mst.xfer(8'hab, 1'b1, rx, ack);
      `CHECK("read ack", 1'b1, ack)
      mst.xfer(8'hff, 1'b0, rx, ack);
      `CHECK("read byte", 8'h40 ^ 8'h5a, rx)
      mst.xfer(8'hff, 1'b1, rx, ack);
      `CHECK("next byte", 8'h41 ^ 8'h5a, rx)
      mst.stop();
      reg_read(2'h1, rx);
      `CHECK("array address", 8'h42, rx)
      // Every select pattern; only the strap answers.
      for (int s = 0; s < 8; s++) begin
         mst.start();
         mst.xfer(8'ha1 | 8'(s << 1), 1'b1, rx, ack);
         `CHECK("select", s == 5, ack)
         if (ack) mst.xfer(8'hff, 1'b1, rx, ack);
         mst.stop();
      end
      wr(8'hba, 8'h00, 8'h00, 0, 1'b0, 1'b0);
      // Half a byte, then a start restarts matching.
      mst.start();
      repeat (4) mst.clk_bit(1'b1, ack);
      wr(8'haa, 8'h10, 8'h00, 0, 1'b1, 1'b0);
      reg_write(2'h3, 8'h00);
      wr(8'haa, 8'h00, 8'h00, 0, 1'b0, 1'b0);
      reg_write(2'h3, 8'h01);
      wr(8'haa, 8'h00, 8'h00, 0, 1'b1, 1'b0);
      print_verdict();
   end

   // Guard against a hang.
   initial begin
      #2000000;
      n_mismatch++;
      print_verdict();
   end
endmodule // eeprom_two_wire_slave_frontend_tb_top
